// File: dv/sird_spi_master.sv
// serial master model on the far side of the slave engine: mode 0, msb first, idle clock low
`timescale 1ns/10ps
module sird_spi_master (
  output logic      o_sck,
  output logic      o_mosi,
  output logic      o_select_n,
  input  wire logic i_miso,
  input  wire logic i_miso_oe
);
  initial begin
    o_sck      = 1'b0;
    o_mosi     = 1'b0;
    o_select_n = 1'b1;
  end

  // settle time after a select change, well past the slave's pin synchronisers
  task automatic sel(input logic lvl);
    o_select_n = lvl;
    #200;
  endtask : sel

  // one frame of n bits, 125 ns clock period; clock stands still outside frames
  task automatic xfer(input int n, input logic [15:0] dout, output logic [15:0] din);
    din = 16'h0000;
    for (int i = n - 1; i >= 0; i--) begin
      o_mosi = dout[i];
      #62.5;
      o_sck = 1'b1;
      // no pull on the data-out line: a released line shows the inverse, so an absent driver never passes
      din = {din[14:0], i_miso_oe ? i_miso : ~i_miso};
      #62.5;
      o_sck = 1'b0;
    end
    // mosi is not held after the frame: show the opposite of the last bit
    o_mosi = ~o_mosi;
    #200;
  endtask : xfer
endmodule : sird_spi_master

// File: dv/testbench.sv
// self-checking bench for the serial flag, enable, clear and data registers
`timescale 1ns/10ps
module testbench;
  localparam int LIMIT = 20000;
  logic        clk;
  logic        reset_n;
  logic [7:0]  addr;
  logic [31:0] wdata;
  logic        wr;
  logic        rd;
  logic [31:0] rdata;
  logic        sck;
  logic        mosi;
  logic        select_n;
  logic        miso;
  logic        miso_oe;
  logic        irq;
  logic [15:0] din;
  int          n_fail;
  int          samples_checked;
  int          cycles;

  sird_ctrl sird_ctrl_i (
    .i_clk      (clk),
    .i_reset_n  (reset_n),
    .i_addr     (addr),
    .i_wdata    (wdata),
    .i_wr       (wr),
    .i_rd       (rd),
    .o_rdata    (rdata),
    .i_sck      (sck),
    .i_mosi     (mosi),
    .i_select_n (select_n),
    .o_miso     (miso),
    .o_miso_oe  (miso_oe),
    .o_irq      (irq)
  );

  sird_spi_master sird_spi_master_i (
    .o_sck      (sck),
    .o_mosi     (mosi),
    .o_select_n (select_n),
    .i_miso     (miso),
    .i_miso_oe  (miso_oe)
  );

  always #5 clk = ~clk;

  task automatic test_done;
    $display("comparisons %0d, mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : test_done

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      $display("Error at %0t: run did not finish in time", $time);
      n_fail++;
      test_done();
    end
  end

  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      $display("Error at %0t: value %h expected %h", $time, got, exp);
      n_fail++;
    end
  endtask : chk_reg

  task automatic chk_bit(input logic got, input logic exp);
    samples_checked++;
    if (got !== exp) begin
      $display("Error at %0t: pin %b expected %b", $time, got, exp);
      n_fail++;
    end
  endtask : chk_bit

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
  endtask : wr_reg

  // read data stand only in the cycle after the strobe edge
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    #1;
    chk_reg(rdata & m, e);
  endtask : rd_chk

  task automatic irq_chk(input logic e);
    repeat (3) @(posedge clk);
    #1;
    chk_bit(irq, e);
  endtask : irq_chk

  initial begin
    clk = 1'b0;
    reset_n = 1'b0;
    addr = 8'h00;
    wdata = 32'h0000_0000;
    wr = 1'b0;
    rd = 1'b0;
    n_fail = 0;
    samples_checked = 0;
    cycles = 0;
    repeat (8) @(posedge clk);
    reset_n <= 1'b1;
    repeat (4) @(posedge clk);
    rd_chk(sird_pkg::OFF_IRQ_ENABLE, 32'hFFFF_FFFF, 32'h0000_0000);
    rd_chk(sird_pkg::OFF_IRQ_FLAGS, 32'h0000_0303, 32'h0000_0201);
    rd_chk(sird_pkg::OFF_FLAG_CLEAR, 32'hFFFF_FFFF, 32'h0000_00FF);
    rd_chk(sird_pkg::OFF_TX_RX_DATA, 32'hFFFF_FFFF, 32'h0000_0000);
    rd_chk(8'h08, 32'hFFFF_FFFF, 32'h0000_0000);
    $display("reset values test done");
    wr_reg(sird_pkg::OFF_IRQ_ENABLE, 32'hFFFF_FFFF);
    rd_chk(sird_pkg::OFF_IRQ_ENABLE, 32'hFFFF_FFFF, 32'h0000_00FF);
    for (int k = 7; k >= 0; k--) begin
      wr_reg(sird_pkg::OFF_IRQ_ENABLE, 32'h0000_0001 << k);
      rd_chk(sird_pkg::OFF_IRQ_ENABLE, 32'hFFFF_FFFF, 32'h0000_0001 << k);
    end
    irq_chk(1'b1);
    wr_reg(sird_pkg::OFF_IRQ_ENABLE, 32'h0000_0000);
    irq_chk(1'b0);
    $display("enable test done");
    wr_reg(sird_pkg::OFF_CTRL, 32'h0000_0071);
    wr_reg(sird_pkg::OFF_FLAG_CLEAR, 32'h0000_0001);
    wr_reg(sird_pkg::OFF_TX_RX_DATA, 32'h0000_005A);
    rd_chk(sird_pkg::OFF_IRQ_FLAGS, 32'h0000_0001, 32'h0000_0000);
    wr_reg(sird_pkg::OFF_FLAG_CLEAR, 32'h0000_00FE);
    rd_chk(sird_pkg::OFF_IRQ_FLAGS, 32'h0000_0001, 32'h0000_0001);
    $display("flush test done");
    wr_reg(sird_pkg::OFF_TX_RX_DATA, 32'h0000_00A5);
    wr_reg(sird_pkg::OFF_IRQ_ENABLE, 32'h0000_0002);
    sird_spi_master_i.sel(1'b0);
    rd_chk(sird_pkg::OFF_IRQ_FLAGS, 32'h0000_0301, 32'h0000_0101);
    chk_bit(miso_oe, 1'b1);
    sird_spi_master_i.xfer(8, 16'h003C, din);
    chk_reg({16'h0000, din}, 32'h0000_00A5);
    sird_spi_master_i.sel(1'b1);
    // the slave preloads the next frame at the last falling edge, so an empty buffer shows as underflow
    rd_chk(sird_pkg::OFF_IRQ_FLAGS, 32'h0000_03FF, 32'h0000_021F);
    chk_bit(miso_oe, 1'b0);
    irq_chk(1'b1);
    rd_chk(sird_pkg::OFF_TX_RX_DATA, 32'hFFFF_FFFF, 32'h0000_003C);
    rd_chk(sird_pkg::OFF_IRQ_FLAGS, 32'h0000_0002, 32'h0000_0000);
    irq_chk(1'b0);
    $display("frame test done");
    wr_reg(sird_pkg::OFF_FLAG_CLEAR, 32'h0000_0001);
    sird_spi_master_i.sel(1'b0);
    sird_spi_master_i.xfer(8, 16'h0011, din);
    chk_reg({16'h0000, din}, 32'h0000_0000);
    sird_spi_master_i.sel(1'b1);
    sird_spi_master_i.sel(1'b0);
    sird_spi_master_i.xfer(8, 16'h0022, din);
    sird_spi_master_i.sel(1'b1);
    rd_chk(sird_pkg::OFF_IRQ_FLAGS, 32'h0000_03FF, 32'h0000_023F);
    wr_reg(sird_pkg::OFF_FLAG_CLEAR, 32'h0000_00FD);
    rd_chk(sird_pkg::OFF_IRQ_FLAGS, 32'h0000_03FF, 32'h0000_023D);
    rd_chk(sird_pkg::OFF_TX_RX_DATA, 32'hFFFF_FFFF, 32'h0000_0011);
    $display("overflow test done");
    wr_reg(sird_pkg::OFF_FLAG_CLEAR, 32'h0000_0001);
    sird_spi_master_i.sel(1'b0);
    sird_spi_master_i.xfer(3, 16'h0005, din);
    sird_spi_master_i.sel(1'b1);
    rd_chk(sird_pkg::OFF_IRQ_FLAGS, 32'h0000_0040, 32'h0000_0040);
    wr_reg(sird_pkg::OFF_CTRL, 32'h0000_0073);
    wr_reg(sird_pkg::OFF_FLAG_CLEAR, 32'h0000_0001);
    rd_chk(sird_pkg::OFF_IRQ_FLAGS, 32'h0000_0080, 32'h0000_0000);
    sird_spi_master_i.sel(1'b0);
    rd_chk(sird_pkg::OFF_IRQ_FLAGS, 32'h0000_0080, 32'h0000_0080);
    sird_spi_master_i.sel(1'b1);
    $display("select error and mode fault test done");
    // 4-bit frames: only the low nibble of a wider word may leave the shifter
    wr_reg(sird_pkg::OFF_CTRL, 32'h0000_0031);
    wr_reg(sird_pkg::OFF_FLAG_CLEAR, 32'h0000_0001);
    wr_reg(sird_pkg::OFF_TX_RX_DATA, 32'hFFFF_FFFA);
    sird_spi_master_i.sel(1'b0);
    sird_spi_master_i.xfer(4, 16'h0009, din);
    sird_spi_master_i.sel(1'b1);
    chk_reg({16'h0000, din}, 32'h0000_000A);
    rd_chk(sird_pkg::OFF_IRQ_FLAGS, 32'h0000_0022, 32'h0000_0002);
    rd_chk(sird_pkg::OFF_TX_RX_DATA, 32'hFFFF_FFFF, 32'h0000_0009);
    $display("frame width test done");
    // second reset in mid-run: enables written earlier must be gone again
    reset_n <= 1'b0;
    repeat (8) @(posedge clk);
    reset_n <= 1'b1;
    repeat (4) @(posedge clk);
    rd_chk(sird_pkg::OFF_IRQ_ENABLE, 32'hFFFF_FFFF, 32'h0000_0000);
    rd_chk(sird_pkg::OFF_IRQ_FLAGS, 32'h0000_03FF, 32'h0000_0201);
    irq_chk(1'b0);
    $display("second reset test done");
    test_done();
  end
endmodule : testbench

// File: logic/sird_ctrl.sv
// serial peripheral flag, enable, clear and data registers with a slave shift engine
// Function
// (R1) irq_enable holds eight enable bits, mode fault at 7 down to tx empty at 0, 1 enabling each.
// (R2) irq_enable reads all zeros after reset so every source starts disabled.
// (R3) an interrupt is requested while any flag is set together with its enable bit.
// (R4) irq_flags resets to 0x1 and bit 0 reads 1 while the transmit buffer is empty; the code reads 0x201 after reset, bit 9 showing select high.
// (R5) irq_flags bit 9 shows the present level of the select input.
// (R6) irq_flags bit 8 reads 1 while a serial transfer keeps the bus busy.
// (R7) in master operation a low select input sets the mode fault flag at bit 7.
// (R8) in slave operation a select error sets bit 6.
// (R9) a receive buffer overflow sets bit 5.
// (R10) overflow is a frame completing while rx not empty is set, and the older frame is kept.
// (R11) in slave operation a transfer needing data software has not supplied sets bit 4.
// (R12) select rising edge sets bit 3 and falling edge sets bit 2, each sticky until cleared.
// (R13) bit 1 is set while received data waits and clears on a data read or a clear write of 0.
// (R14) flag_clear reads 0xFF, a 0 in bits 7 to 1 clears that flag, a 1 does nothing.
// (R15) a 0 written to flag_clear bit 0 empties transmit buffer and shift register, tx empty reads 1.
// (R16) tx_rx_data uses bits 15:0, a write queues a frame, a read returns the held received one, the older frame after an overflow.
// (R17) frame length is the width field plus one, 4 to 16 bits, and only those low bits shift.
//
// Local design decision: the strobed register port.
`timescale 1ns/10ps
module sird_ctrl (
  input  wire logic        i_clk,
  input  wire logic        i_reset_n,
  input  wire logic [7:0]  i_addr,
  input  wire logic [31:0] i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  output logic      [31:0] o_rdata,
  input  wire logic        i_sck,
  input  wire logic        i_mosi,
  input  wire logic        i_select_n,
  output logic             o_miso,
  output logic             o_miso_oe,
  output logic             o_irq
);
  logic               rst_meta_reg;
  logic               rst_n_reg;
  logic               rst_n;
  logic [2:0]         pin_sync;
  logic               sck_s;
  logic               mosi_s;
  logic               sel_s;
  logic               sck_prev_reg;
  logic               sel_prev_reg;
  logic               sck_rise;
  logic               sck_fall;
  logic               sel_rise;
  logic               sel_fall;
  logic               enable_reg;
  logic               master_reg;
  logic [3:0]         width_reg;
  logic [3:0]         eff_width;
  logic [15:0]        frame_mask;
  logic [7:0]         irq_enable_reg;
  logic [15:0]        tx_data_reg;
  logic               tx_empty_reg;
  logic [15:0]        rx_data_reg;
  logic [15:0]        shift_in_reg;
  logic [15:0]        shift_out_reg;
  logic [15:0]        shift_out_next;
  logic [15:0]        rx_frame;
  logic [3:0]         bit_cnt_reg;
  logic               reload_reg;
  logic               miso_reg;
  logic               irq_reg;
  logic [31:0]        rdata_reg;
  logic [31:0]        rdata_next;
  sird_pkg::sird_state_t state_reg;
  logic               slave_on;
  logic               wr_ctrl;
  logic               wr_ien;
  logic               wr_clear;
  logic               wr_data;
  logic               rd_data;
  logic [7:0]         clr_vec;
  logic               flush;
  logic               load_now;
  logic               frame_done;
  logic               busy;
  logic [7:1]         set_vec;
  logic [7:1]         flag_q;
  logic [7:0]         flags;

  // reset enters asynchronously, is released through two flops
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      rst_meta_reg <= 1'b0;
      rst_n_reg    <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_n_reg    <= rst_meta_reg;
    end
  end
  assign rst_n = rst_n_reg;

  // select idles high, so its synchroniser resets high to avoid a false edge
  sird_sync2 #(.W(3), .RST(3'b001)) u_pin_sync (
    .i_clk   (i_clk),
    .i_rst_n (rst_n),
    .i_async ({i_sck, i_mosi, i_select_n}),
    .o_sync  (pin_sync)
  );
  assign sck_s  = pin_sync[2];
  assign mosi_s = pin_sync[1];
  assign sel_s  = pin_sync[0];

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      sck_prev_reg <= 1'b0;
      sel_prev_reg <= 1'b1;
    end else begin
      sck_prev_reg <= sck_s;
      sel_prev_reg <= sel_s;
    end
  end
  assign sck_rise = sck_s & ~sck_prev_reg;
  assign sck_fall = ~sck_s & sck_prev_reg;
  assign sel_rise = sel_s & ~sel_prev_reg;
  assign sel_fall = ~sel_s & sel_prev_reg;

  // register port decode
  assign wr_ctrl  = i_wr && (i_addr == sird_pkg::OFF_CTRL);
  assign wr_ien   = i_wr && (i_addr == sird_pkg::OFF_IRQ_ENABLE);
  assign wr_clear = i_wr && (i_addr == sird_pkg::OFF_FLAG_CLEAR);
  assign wr_data  = i_wr && (i_addr == sird_pkg::OFF_TX_RX_DATA);
  assign rd_data  = i_rd && (i_addr == sird_pkg::OFF_TX_RX_DATA);
  assign clr_vec  = wr_clear ? ~i_wdata[7:0] : 8'h00; // R14
  assign flush    = clr_vec[sird_pkg::BIT_TX_EMPTY];

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      enable_reg <= 1'b0;
      master_reg <= 1'b0;
      width_reg  <= sird_pkg::WIDTH_RST;
    end else if (wr_ctrl) begin
      enable_reg <= i_wdata[sird_pkg::CTRL_ENABLE_BIT];
      master_reg <= i_wdata[sird_pkg::CTRL_MASTER_BIT];
      width_reg  <= i_wdata[sird_pkg::CTRL_WIDTH_MSB:sird_pkg::CTRL_WIDTH_LSB];
    end
  end

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_enable_reg <= sird_pkg::IRQ_ENABLE_RST; // R2
    end else if (wr_ien) begin
      irq_enable_reg <= i_wdata[7:0]; // R1
    end
  end

  // widths below four bits are not legal frames; they run as four
  assign eff_width  = (width_reg < sird_pkg::WIDTH_MIN) ? sird_pkg::WIDTH_MIN : width_reg; // R17
  assign frame_mask = 16'hFFFF >> (sird_pkg::WIDTH_MAX - eff_width); // R17
  assign rx_frame   = {shift_in_reg[14:0], mosi_s} & frame_mask; // R17

  assign slave_on   = enable_reg & ~master_reg;
  assign load_now   = slave_on && (((state_reg == sird_pkg::ST_IDLE) && !sel_s)
                      || ((state_reg == sird_pkg::ST_SHIFT) && !sel_s && sck_fall && reload_reg));
  assign frame_done = (state_reg == sird_pkg::ST_SHIFT) && slave_on && !sel_s && sck_rise
                      && (bit_cnt_reg == eff_width);
  assign busy       = (state_reg == sird_pkg::ST_SHIFT); // R6
  assign shift_out_next = shift_out_reg << 1;

  // slave engine: mode 0, most significant bit first
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg     <= sird_pkg::ST_IDLE;
      bit_cnt_reg   <= 4'h0;
      reload_reg    <= 1'b0;
      shift_in_reg  <= sird_pkg::DATA_RST;
      shift_out_reg <= sird_pkg::DATA_RST;
      miso_reg      <= 1'b0;
    end else if (flush) begin
      shift_out_reg <= sird_pkg::DATA_RST; // R15
      miso_reg      <= 1'b0;
    end else begin
      unique case (state_reg)
        sird_pkg::ST_IDLE: begin
          if (load_now) begin
            state_reg     <= sird_pkg::ST_SHIFT;
            bit_cnt_reg   <= 4'h0;
            reload_reg    <= 1'b0;
            shift_out_reg <= tx_empty_reg ? sird_pkg::DATA_RST : tx_data_reg;
            miso_reg      <= tx_empty_reg ? 1'b0 : tx_data_reg[eff_width];
          end
        end
        sird_pkg::ST_SHIFT: begin
          if (sel_s || !slave_on) begin
            state_reg <= sird_pkg::ST_IDLE;
          end else if (sck_rise) begin
            shift_in_reg <= {shift_in_reg[14:0], mosi_s};
            bit_cnt_reg  <= frame_done ? 4'h0 : bit_cnt_reg + 4'h1;
            reload_reg   <= frame_done;
          end else if (load_now) begin
            reload_reg    <= 1'b0;
            shift_out_reg <= tx_empty_reg ? sird_pkg::DATA_RST : tx_data_reg;
            miso_reg      <= tx_empty_reg ? 1'b0 : tx_data_reg[eff_width];
          end else if (sck_fall) begin
            shift_out_reg <= shift_out_next;
            miso_reg      <= shift_out_next[eff_width];
          end
        end
      endcase
    end
  end

  // transmit buffer: a write fills it, a load into the shifter or a flush empties it
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_data_reg  <= sird_pkg::DATA_RST;
      tx_empty_reg <= sird_pkg::IRQ_FLAGS_RST[sird_pkg::BIT_TX_EMPTY]; // R4
    end else if (flush) begin
      tx_empty_reg <= 1'b1; // R15
    end else if (wr_data) begin
      tx_data_reg  <= i_wdata[15:0]; // R16
      tx_empty_reg <= 1'b0; // R4
    end else if (load_now) begin
      tx_empty_reg <= 1'b1; // R4
    end
  end

  // the held frame is never overwritten while rx not empty is set; the newcomer is dropped
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_data_reg <= sird_pkg::DATA_RST;
    end else if (frame_done && !flag_q[sird_pkg::BIT_RX_NOT_EMPTY]) begin
      rx_data_reg <= rx_frame; // R10
    end
  end

  assign set_vec[sird_pkg::BIT_MODE_FAULT]   = enable_reg & master_reg & ~sel_s; // R7
  assign set_vec[sird_pkg::BIT_SELECT_ERROR] = slave_on && busy && sel_rise && (bit_cnt_reg != 4'h0); // R8
  assign set_vec[sird_pkg::BIT_RX_OVERFLOW]  = frame_done & flag_q[sird_pkg::BIT_RX_NOT_EMPTY]; // R9 R10
  assign set_vec[sird_pkg::BIT_TX_UNDERFLOW] = load_now & tx_empty_reg; // R11
  assign set_vec[sird_pkg::BIT_SELECT_RISE]  = sel_rise; // R12
  assign set_vec[sird_pkg::BIT_SELECT_FALL]  = sel_fall; // R12
  assign set_vec[sird_pkg::BIT_RX_NOT_EMPTY] = frame_done & ~flag_q[sird_pkg::BIT_RX_NOT_EMPTY]; // R13

  for (genvar g = 1; g < 8; g++) begin : g_flag
    sird_flag u_flag (
      .i_clk   (i_clk),
      .i_rst_n (rst_n),
      .i_set   (set_vec[g]),
      .i_clear (clr_vec[g] | ((g == sird_pkg::BIT_RX_NOT_EMPTY) && rd_data)), // R13 R14
      .o_flag  (flag_q[g])
    );
  end
  assign flags = {flag_q, tx_empty_reg};

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= |(flags & irq_enable_reg); // R3
    end
  end

  always_comb begin
    rdata_next = 32'h0000_0000;
    if (i_rd) begin
      unique case (i_addr)
        sird_pkg::OFF_CTRL:       rdata_next = {24'h00_0000, width_reg, 2'b00, master_reg, enable_reg};
        sird_pkg::OFF_IRQ_ENABLE: rdata_next = {24'h00_0000, irq_enable_reg}; // R1
        sird_pkg::OFF_IRQ_FLAGS:  rdata_next = {22'h00_0000, sel_s, busy, flags}; // R5 R6
        sird_pkg::OFF_FLAG_CLEAR: rdata_next = sird_pkg::FLAG_CLEAR_RD; // R14
        sird_pkg::OFF_TX_RX_DATA: rdata_next = {16'h0000, rx_data_reg}; // R16
        default:                  rdata_next = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_reg <= 32'h0000_0000;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  assign o_rdata   = rdata_reg;
  assign o_miso    = miso_reg;
  assign o_miso_oe = slave_on & busy;
  assign o_irq     = irq_reg;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!rst_n);

  sequence s_flush_req;
    wr_clear && !i_wdata[sird_pkg::BIT_TX_EMPTY];
  endsequence
  sequence s_frame_into_full;
    frame_done && flag_q[sird_pkg::BIT_RX_NOT_EMPTY];
  endsequence
  sequence s_data_read;
    rd_data && !set_vec[sird_pkg::BIT_RX_NOT_EMPTY];
  endsequence

  property p_ien_write;
    wr_ien |=> irq_enable_reg == $past(i_wdata[7:0]);
  endproperty
  a_ien_write: assert property (p_ien_write) else $error("irq_enable did not take written value"); // R1

  property p_irq_follow;
    ##1 o_irq == $past(|(flags & irq_enable_reg));
  endproperty
  a_irq_follow: assert property (p_irq_follow) else $error("irq does not follow enabled flags"); // R3

  property p_tx_fill;
    wr_data |=> !flags[sird_pkg::BIT_TX_EMPTY] && tx_data_reg == $past(i_wdata[15:0]);
  endproperty
  a_tx_fill: assert property (p_tx_fill) else $error("data write did not fill transmit buffer"); // R4

  property p_level_read;
    (i_rd && i_addr == sird_pkg::OFF_IRQ_FLAGS) |=> o_rdata[9] == $past(sel_s) && o_rdata[8] == $past(busy);
  endproperty
  a_level_read: assert property (p_level_read) else $error("level or busy bit misreported"); // R5

  property p_mode_fault;
    (enable_reg && master_reg && !sel_s) |=> flags[sird_pkg::BIT_MODE_FAULT];
  endproperty
  a_mode_fault: assert property (p_mode_fault) else $error("mode fault not flagged"); // R7

  property p_overflow;
    s_frame_into_full |=> flags[sird_pkg::BIT_RX_OVERFLOW] && $stable(rx_data_reg);
  endproperty
  a_overflow: assert property (p_overflow) else $error("overflow not flagged or frame overwritten"); // R10

  // a software clear one cycle after the edge is legal, so the second cycle allows for it
  property p_select_rise;
    sel_rise |=> flags[sird_pkg::BIT_SELECT_RISE]
                 ##1 (flags[sird_pkg::BIT_SELECT_RISE] || $past(clr_vec[sird_pkg::BIT_SELECT_RISE]));
  endproperty
  a_select_rise: assert property (p_select_rise) else $error("select rise flag not sticky"); // R12

  property p_rx_read_clear;
    s_data_read |=> !flags[sird_pkg::BIT_RX_NOT_EMPTY];
  endproperty
  a_rx_read_clear: assert property (p_rx_read_clear) else $error("data read left rx not empty set"); // R13

  property p_clear_reads_ones;
    (i_rd && i_addr == sird_pkg::OFF_FLAG_CLEAR) |=> o_rdata == sird_pkg::FLAG_CLEAR_RD;
  endproperty
  a_clear_reads_ones: assert property (p_clear_reads_ones) else $error("flag_clear read not 0xFF"); // R14

  property p_flush;
    s_flush_req |=> flags[sird_pkg::BIT_TX_EMPTY] && shift_out_reg == 16'h0000;
  endproperty
  a_flush: assert property (p_flush) else $error("flush left transmit data behind"); // R15

  property p_data_upper;
    rd_data |=> o_rdata == {16'h0000, $past(rx_data_reg)};
  endproperty
  a_data_upper: assert property (p_data_upper) else $error("data read wrong or upper bits set"); // R16
endmodule : sird_ctrl

// File: logic/sird_flag.sv
// one sticky status flag: hardware set wins over a software clear in the same cycle
`timescale 1ns/10ps
module sird_flag (
  input  wire logic i_clk,
  input  wire logic i_rst_n,
  input  wire logic i_set,
  input  wire logic i_clear,
  output logic      o_flag
);
  logic flag_reg;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      flag_reg <= 1'b0;
    end else if (i_set) begin
      flag_reg <= 1'b1;
    end else if (i_clear) begin
      flag_reg <= 1'b0;
    end
  end

  assign o_flag = flag_reg;
endmodule : sird_flag

// File: logic/sird_pkg.sv
// package: register map, field positions, reset values and engine states of the serial flag/data block
package sird_pkg;
  // register offsets (byte addresses on the plain register port)
  localparam logic [7:0]  OFF_CTRL        = 8'h00;
  localparam logic [7:0]  OFF_IRQ_ENABLE  = 8'h04;
  localparam logic [7:0]  OFF_IRQ_FLAGS   = 8'h10;
  localparam logic [7:0]  OFF_FLAG_CLEAR  = 8'h14;
  localparam logic [7:0]  OFF_TX_RX_DATA  = 8'h18;

  // flag and enable bit positions; 7 to 0 shared by irq_enable, irq_flags and flag_clear, 8 and 9 in irq_flags only
  localparam int unsigned BIT_MODE_FAULT   = 7;
  localparam int unsigned BIT_SELECT_ERROR = 6;
  localparam int unsigned BIT_RX_OVERFLOW  = 5;
  localparam int unsigned BIT_TX_UNDERFLOW = 4;
  localparam int unsigned BIT_SELECT_RISE  = 3;
  localparam int unsigned BIT_SELECT_FALL  = 2;
  localparam int unsigned BIT_RX_NOT_EMPTY = 1;
  localparam int unsigned BIT_TX_EMPTY     = 0;
  localparam int unsigned BIT_BUSY         = 8;
  localparam int unsigned BIT_SELECT_LEVEL = 9;

  // control register fields
  localparam int unsigned CTRL_ENABLE_BIT = 0;
  localparam int unsigned CTRL_MASTER_BIT = 1;
  localparam int unsigned CTRL_WIDTH_LSB  = 4;
  localparam int unsigned CTRL_WIDTH_MSB  = 7;

  // reset values
  localparam logic [7:0]  IRQ_ENABLE_RST  = 8'h00;
  localparam logic [31:0] IRQ_FLAGS_RST   = 32'h0000_0001;
  localparam logic [31:0] FLAG_CLEAR_RD   = 32'h0000_00FF;
  localparam logic [15:0] DATA_RST        = 16'h0000;
  localparam logic [3:0]  WIDTH_RST       = 4'h7;
  localparam logic [3:0]  WIDTH_MIN       = 4'h3;
  localparam logic [3:0]  WIDTH_MAX       = 4'hF;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b01,
    ST_SHIFT = 2'b10
  } sird_state_t;
endpackage : sird_pkg

// File: logic/sird_sync2.sv
// two-flop synchroniser for pins arriving from outside the clock domain
`timescale 1ns/10ps
module sird_sync2 #(
  parameter int unsigned   W   = 1,
  parameter logic [W-1:0]  RST = '0
) (
  input  wire logic         i_clk,
  input  wire logic         i_rst_n,
  input  wire logic [W-1:0] i_async,
  output logic      [W-1:0] o_sync
);
  logic [W-1:0] meta_reg;
  logic [W-1:0] sync_reg;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      meta_reg <= RST;
      sync_reg <= RST;
    end else begin
      meta_reg <= i_async;
      sync_reg <= meta_reg;
    end
  end

  assign o_sync = sync_reg;
endmodule : sird_sync2
